/* src/ups_seq.sv */
// Power-up, reset and interface-protection sequencer of a ULPI transceiver.
// Assumes pins arrive asynchronous, the PLL clock is sampled as a level, and
// the register decoder sits on ref_clk_in and pulses the reset-bit write.
`timescale 1ns/10ps
`default_nettype none
module ups_seq #(
    parameter int unsigned HW_RELEASE_CYCLES = ups_pkg::HW_RST_RELEASE_CYC,
    parameter int unsigned SW_RESET_CYCLES = ups_pkg::SW_RST_CYC
) (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic core_regulator_rail_in,
    input wire logic chip_select_powerdown_pin_in,
    input wire logic hw_reset_n_in,
    input wire logic stp_in,
    input wire logic pll_clk_in,
    input wire logic pll_lock_in,
    input wire logic func_reset_write_in,
    input wire logic bus_protect_disable_bit_in,
    input wire logic [7:0] rxcmd_status_in,
    output ups_pkg::ups_pins_t pins_out,
    output logic func_reset_bit_out,
    output logic powered_down_out,
    output logic internal_reset_out
);
    localparam int unsigned CW = 16;
    localparam logic [CW-1:0] HIGH_MIN = CW'(ups_pkg::RAIL_HIGH_MIN_CYC);
    localparam logic [CW-1:0] LOW_MIN = CW'(ups_pkg::RAIL_LOW_MIN_CYC);
    localparam logic [CW-1:0] POR_LEN = CW'(ups_pkg::POR_PULSE_CYC);
    localparam logic [CW-1:0] HW_LEN = CW'(HW_RELEASE_CYCLES);
    localparam logic [CW-1:0] SW_LEN = CW'(SW_RESET_CYCLES);
    localparam logic [CW-1:0] RX_LEN = CW'(ups_pkg::RXCMD_DIR_CYC);
    localparam logic [ups_pkg::PIN_SYNC_W-1:0] SYNC_RST = 6'h06;

    ups_pkg::ups_state_t state;
    ups_pkg::ups_state_t next_state;
    ups_pkg::ups_pins_t next_pins;
    logic [ups_pkg::PIN_SYNC_W-1:0] pin_raw;
    logic [ups_pkg::PIN_SYNC_W-1:0] pin_sync;
    logic rail_ok;
    logic cs_pd;
    logic rst_pin_n;
    logic stp;
    logic pll_clk;
    logic pll_lock;
    logic pll_clk_d;
    logic iface_rise;
    logic [CW-1:0] high_cnt;
    logic [CW-1:0] low_cnt;
    logic [CW-1:0] por_cnt;
    logic por_armed;
    logic por_active;
    logic por_fire;
    logic [CW-1:0] iface_cnt;
    logic clk_run;
    logic next_clk_run;
    logic next_func_reset;
    logic dir_high;

    assign pin_raw = {pll_lock_in, pll_clk_in, stp_in, hw_reset_n_in,
                      chip_select_powerdown_pin_in, core_regulator_rail_in};

    // Reset pin starts inactive (high) and power-down pin starts asserted, its safe level
    ups_sync #(
        .WIDTH(ups_pkg::PIN_SYNC_W)
    ) u_pin_sync (
        .clk_in(ref_clk_in),
        .rst_in(sys_rst_in),
        .async_in(pin_raw),
        .reset_val_in(SYNC_RST),
        .sync_out(pin_sync)
    );

    assign rail_ok = pin_sync[ups_pkg::PIN_RAIL];
    assign cs_pd = pin_sync[ups_pkg::PIN_CS_PD];
    assign rst_pin_n = pin_sync[ups_pkg::PIN_RESET_N];
    assign stp = pin_sync[ups_pkg::PIN_STP];
    assign pll_clk = pin_sync[ups_pkg::PIN_PLL_CLK];
    assign pll_lock = pin_sync[ups_pkg::PIN_PLL_LOCK];

    // Edge finder on the sampled interface clock
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pll_clk_d <= 1'b0;
        end else begin
            pll_clk_d <= pll_clk;
        end
    end
    assign iface_rise = pll_clk & ~pll_clk_d;

    // Rail watcher: a trip needs the rail high for the minimum width; a
    // dip re-arms only when it outlasts the low minimum, shorter dips vanish.
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || cs_pd) begin
            high_cnt <= '0;
            low_cnt <= '0;
            por_armed <= 1'b1;
        end else if (rail_ok) begin
            low_cnt <= '0;
            if (high_cnt < HIGH_MIN) begin
                high_cnt <= high_cnt + CW'(1);
            end
            if (por_fire) begin
                por_armed <= 1'b0;
            end
        end else begin
            high_cnt <= '0;
            if (low_cnt < LOW_MIN) begin
                low_cnt <= low_cnt + CW'(1);
            end else begin
                por_armed <= 1'b1;
            end
        end
    end
    assign por_fire = por_armed && rail_ok && (high_cnt == HIGH_MIN - CW'(1));

    // Pulse stretcher standing in for the delay element
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || cs_pd) begin
            por_cnt <= '0;
            por_active <= 1'b0;
        end else if (por_fire) begin
            por_cnt <= POR_LEN - CW'(1);
            por_active <= 1'b1;
        end else if (por_cnt != '0) begin
            por_cnt <= por_cnt - CW'(1);
        end else begin
            por_active <= 1'b0;
        end
    end

    // Sequencer. Reset sources take effect in the cycle they are seen,
    // while only the PLL-wait, release, soft-reset and status-byte exits wait for an interface clock rising edge.
    always_comb begin
        next_state = state;
        if (cs_pd) begin
            next_state = ups_pkg::UPS_PWR_DOWN;
        end else if (por_fire || por_active) begin
            next_state = ups_pkg::UPS_POR;
        end else if (!rst_pin_n) begin
            next_state = ups_pkg::UPS_HW_RST;
        end else begin
            unique case (state)
                ups_pkg::UPS_PWR_DOWN: next_state = ups_pkg::UPS_POR;
                ups_pkg::UPS_POR: begin
                    // Hold until a pulse has fired and run out; a dead rail never leaves
                    if (!por_armed) begin
                        next_state = ups_pkg::UPS_WAIT_PLL;
                    end
                end
                ups_pkg::UPS_WAIT_PLL: begin
                    if (pll_lock && iface_rise) begin
                        next_state = ups_pkg::UPS_IDLE;
                    end
                end
                ups_pkg::UPS_HW_RST: next_state = ups_pkg::UPS_HW_RELEASE;
                ups_pkg::UPS_HW_RELEASE: begin
                    // Status byte rides inside the release count, so direction
                    // still drops on the fourth interface edge after the pin
                    if (iface_rise && iface_cnt == HW_LEN - RX_LEN - CW'(1)) begin
                        next_state = ups_pkg::UPS_SEND_RXCMD;
                    end
                end
                ups_pkg::UPS_SW_RST: begin
                    if (iface_rise && iface_cnt == SW_LEN - CW'(1)) begin
                        next_state = ups_pkg::UPS_SEND_RXCMD;
                    end
                end
                ups_pkg::UPS_SEND_RXCMD: begin
                    if (iface_rise && iface_cnt == RX_LEN - CW'(1)) begin
                        next_state = ups_pkg::UPS_IDLE;
                    end
                end
                ups_pkg::UPS_IDLE: begin
                    if (func_reset_write_in) begin
                        next_state = ups_pkg::UPS_SW_RST;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            state <= ups_pkg::UPS_PWR_DOWN;
        end else begin
            state <= next_state;
        end
    end

    // Interface cycle counter, cleared on every state change
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in || next_state != state) begin
            iface_cnt <= '0;
        end else if (iface_rise) begin
            iface_cnt <= iface_cnt + CW'(1);
        end
    end

    // Soft reset bit: set by the write, cleared by the sequencer when done.
    // A write landing on the completion cycle is ignored and the bit clears.
    always_comb begin
        next_func_reset = func_reset_bit_out;
        if (state == ups_pkg::UPS_SW_RST && next_state != ups_pkg::UPS_SW_RST) begin
            next_func_reset = 1'b0;
        end
        if (next_state == ups_pkg::UPS_SW_RST && state != ups_pkg::UPS_SW_RST) begin
            next_func_reset = 1'b1;
        end
        if (next_state == ups_pkg::UPS_POR || next_state == ups_pkg::UPS_HW_RST ||
            next_state == ups_pkg::UPS_PWR_DOWN) begin
            next_func_reset = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            func_reset_bit_out <= 1'b0;
        end else begin
            func_reset_bit_out <= next_func_reset;
        end
    end

    // Clock output runs once the sequencer leaves the PLL wait and stops in power-down or power-on reset
    always_comb begin
        next_clk_run = clk_run;
        if (next_state == ups_pkg::UPS_PWR_DOWN || next_state == ups_pkg::UPS_POR ||
            next_state == ups_pkg::UPS_WAIT_PLL) begin
            next_clk_run = 1'b0;
        end else if (state == ups_pkg::UPS_WAIT_PLL) begin
            next_clk_run = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            clk_run <= 1'b0;
        end else begin
            clk_run <= next_clk_run;
        end
    end

    // Pin drive follows the next state so outputs stay registered
    assign dir_high = (next_state == ups_pkg::UPS_WAIT_PLL) ||
                      (next_state == ups_pkg::UPS_HW_RST) ||
                      (next_state == ups_pkg::UPS_HW_RELEASE) ||
                      (next_state == ups_pkg::UPS_SW_RST) ||
                      (next_state == ups_pkg::UPS_SEND_RXCMD);

    always_comb begin
        next_pins.clk = next_clk_run & pll_clk;
        next_pins.clk_oe_n = 1'b0;
        next_pins.dir = dir_high;
        next_pins.dir_oe_n = 1'b0;
        next_pins.nxt = 1'b0;
        next_pins.nxt_oe_n = 1'b0;
        next_pins.data = dir_high ? rxcmd_status_in : ups_pkg::DATA_RESET;
        // Direction low: the link owns the data lines
        next_pins.data_oe_n = ~dir_high;
        next_pins.stp_pullup_en = 1'b1;
        // Pull-downs only guard a floating bus the link should be driving
        next_pins.data_pulldown_en = ~dir_high & stp & ~bus_protect_disable_bit_in;
        if (next_state == ups_pkg::UPS_PWR_DOWN || next_state == ups_pkg::UPS_POR) begin
            next_pins.clk = 1'b0;
            next_pins.clk_oe_n = 1'b1;
            next_pins.dir = 1'b0;
            next_pins.dir_oe_n = 1'b1;
            next_pins.nxt_oe_n = 1'b1;
            next_pins.data = ups_pkg::DATA_RESET;
            next_pins.data_oe_n = 1'b1;
            next_pins.data_pulldown_en = 1'b0;
            next_pins.stp_pullup_en = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            pins_out <= '{clk: 1'b0, clk_oe_n: 1'b1, dir: 1'b0, dir_oe_n: 1'b1,
                          nxt: 1'b0, nxt_oe_n: 1'b1, data: ups_pkg::DATA_RESET,
                          data_oe_n: 1'b1, data_pulldown_en: 1'b0, stp_pullup_en: 1'b0};
        end else begin
            pins_out <= next_pins;
        end
    end

    // Status flags
    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            powered_down_out <= 1'b1;
            internal_reset_out <= 1'b1;
        end else begin
            powered_down_out <= (next_state == ups_pkg::UPS_PWR_DOWN);
            internal_reset_out <= (next_state == ups_pkg::UPS_POR) ||
                                  (next_state == ups_pkg::UPS_HW_RST) ||
                                  (next_state == ups_pkg::UPS_HW_RELEASE) ||
                                  (next_state == ups_pkg::UPS_SW_RST);
        end
    end

endmodule
`default_nettype wire

/* src/ups_pkg.sv */
// Package for the power-up and reset sequencer of the ULPI transceiver.
// Assumes a 200 MHz sequencer clock; all pin inputs are synchronised before use.
package ups_pkg;

    // Sequencer clock in MHz (5 ns period)
    localparam int unsigned CLK_MHZ = 200;

    // Times in ns; plain defaults, the rail figures are not printed
    localparam int unsigned RAIL_HIGH_MIN_NS = 100;
    localparam int unsigned RAIL_LOW_MIN_NS = 200;
    localparam int unsigned POR_PULSE_NS = 500;

    // Least times round up to whole cycles
    localparam int unsigned RAIL_HIGH_MIN_CYC = (RAIL_HIGH_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned RAIL_LOW_MIN_CYC = (RAIL_LOW_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned POR_PULSE_CYC = (POR_PULSE_NS * CLK_MHZ + 999) / 1000;

    // Interface clock cycles
    localparam int unsigned HW_RST_RELEASE_CYC = 4;
    localparam int unsigned SW_RST_CYC = 8;
    localparam int unsigned RXCMD_DIR_CYC = 2;

    // Width of the pin synchroniser bank and bit positions inside it
    localparam int unsigned PIN_SYNC_W = 6;
    localparam int unsigned PIN_RAIL = 0;
    localparam int unsigned PIN_CS_PD = 1;
    localparam int unsigned PIN_RESET_N = 2;
    localparam int unsigned PIN_STP = 3;
    localparam int unsigned PIN_PLL_CLK = 4;
    localparam int unsigned PIN_PLL_LOCK = 5;

    // Reset values of the interface pins
    localparam logic [7:0] DATA_RESET = 8'h00;

    typedef enum logic [2:0] {
        UPS_PWR_DOWN,
        UPS_POR,
        UPS_WAIT_PLL,
        UPS_HW_RST,
        UPS_HW_RELEASE,
        UPS_SW_RST,
        UPS_SEND_RXCMD,
        UPS_IDLE
    } ups_state_t;

    // Interface pin drive; every output enable is low while the pin is driven, pull enables are high when on
    typedef struct packed {
        logic clk;
        logic clk_oe_n;
        logic dir;
        logic dir_oe_n;
        logic nxt;
        logic nxt_oe_n;
        logic [7:0] data;
        logic data_oe_n;
        logic data_pulldown_en;
        logic stp_pullup_en;
    } ups_pins_t;

endpackage

/* src/ups_sync.sv */
// Two-flop synchroniser bank for asynchronous pin levels.
// Assumes the inputs are levels; only the second flop is visible outside.
`timescale 1ns/10ps
`default_nettype none
module ups_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [WIDTH-1:0] async_in,
    input wire logic [WIDTH-1:0] reset_val_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_in) begin
                if (rst_in) begin
                    meta[i] <= reset_val_in[i];
                    sync_out[i] <= reset_val_in[i];
                end else begin
                    meta[i] <= async_in[i];
                    sync_out[i] <= meta[i];
                end
            end
        end
    endgenerate
endmodule
`default_nettype wire

/* dv/ups_seq_props.sv */
// Assertions on the port behaviour of the power-up and reset sequencer.
// Assumes it is bound to ups_seq and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module ups_seq_props (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic chip_select_powerdown_pin_in,
    input wire logic hw_reset_n_in,
    input wire logic bus_protect_disable_bit_in,
    input wire ups_pkg::ups_pins_t pins_out,
    input wire logic func_reset_bit_out,
    input wire logic powered_down_out,
    input wire logic internal_reset_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (sys_rst_in);

    property p_dir_drive;
        pins_out.dir && !pins_out.dir_oe_n |-> !pins_out.nxt && !pins_out.data_oe_n;
    endproperty
    a_dir_drive: assert property (p_dir_drive) else $error("nxt or data wrong with dir");
    property p_pd_tri;
        powered_down_out |-> &{pins_out.clk_oe_n, pins_out.dir_oe_n, pins_out.nxt_oe_n,
            pins_out.data_oe_n};
    endproperty
    a_pd_tri: assert property (p_pd_tri) else $error("pin driven in power-down");
    property p_cs_enter;
        $rose(chip_select_powerdown_pin_in) |-> ##[1:4] powered_down_out;
    endproperty
    a_cs_enter: assert property (p_cs_enter) else $error("no power-down");
    property p_hw_dir;
        $fell(hw_reset_n_in) && !powered_down_out |-> ##[1:4] (pins_out.dir && internal_reset_out);
    endproperty
    a_hw_dir: assert property (p_hw_dir) else $error("dir low in pin reset");
    property p_rst_end;
        $fell(internal_reset_out) && !powered_down_out |-> pins_out.dir && !pins_out.dir_oe_n
            && !pins_out.nxt && !pins_out.nxt_oe_n;
    endproperty
    a_rst_end: assert property (p_rst_end) else $error("pins undefined after reset");
    property p_rxcmd;
        $fell(internal_reset_out) && !powered_down_out |-> pins_out.dir [*8];
    endproperty
    a_rxcmd: assert property (p_rxcmd) else $error("no status byte after reset");
    property p_protect_off;
        bus_protect_disable_bit_in [*3] |-> !pins_out.data_pulldown_en;
    endproperty
    a_protect_off: assert property (p_protect_off) else $error("pull-down while off");
    property p_pullup;
        !powered_down_out && !internal_reset_out |-> pins_out.stp_pullup_en;
    endproperty
    a_pullup: assert property (p_pullup) else $error("stop pull-up off");
    property p_sw_dir;
        func_reset_bit_out |-> pins_out.dir && internal_reset_out;
    endproperty
    a_sw_dir: assert property (p_sw_dir) else $error("dir low in soft reset");
    property p_sw_end;
        $rose(func_reset_bit_out) |-> ##[1:1000] !func_reset_bit_out;
    endproperty
    a_sw_end: assert property (p_sw_end) else $error("reset bit never clears");
endmodule
`default_nettype wire

/* dv/ups_link_model.sv */
// Link controller model: resets the transceiver after three low direction samples.
// Assumes the interface clock pin is sampled on the sequencer clock.
`timescale 1ns/10ps
`default_nettype none
module ups_link_model (
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic go_in,
    input wire logic dir_in,
    input wire logic ifclk_in,
    input wire logic hw_reset_n_in,
    input wire logic stp_req_in,
    output logic func_reset_write_out,
    output logic stp_out
);
    logic ifclk_prev;
    logic done;
    int low_cnt;
    // Stop forced low while the reset pin is low, whatever the bench asks
    assign stp_out = stp_req_in & hw_reset_n_in;
    // Data lines not modelled: the link holds 00h while direction is low
    // Status bytes are never read before the reset is issued
    always_ff @(posedge ref_clk_in) begin
        ifclk_prev <= ifclk_in;
        func_reset_write_out <= 1'b0;
        if (sys_rst_in || !go_in) begin
            low_cnt <= 0;
            done <= 1'b0;
        end else if (ifclk_in && !ifclk_prev) begin
            low_cnt <= dir_in ? 0 : low_cnt + 1;
            if (!dir_in && low_cnt >= 2 && !done) begin
                func_reset_write_out <= 1'b1;
                done <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

/* dv/test_ulpi_phy_powerup_reset_seq.sv */
// Self-checking bench for the power-up and reset sequencer.
// Assumes the link model stands on the far side; the PLL clock is free running.
`timescale 1ns/10ps
`default_nettype none
module test_ulpi_phy_powerup_reset_seq;
    logic ref_clk_in = 0, sys_rst_in = 1, rail = 0, cs_pd = 1, rst_n = 1, stp_req = 0;
    logic pll_clk = 0, lock = 0, dis = 0, go = 0, wr, stp, bit_o, pd, ir;
    logic [7:0] status = 8'h00;
    ups_pkg::ups_pins_t pins;
    int err_count = 0, checked = 0, cyc = 0, ifc = 0, base, rises;
    logic last_clk;

    always #2.5 ref_clk_in = ~ref_clk_in;
    always #32 pll_clk = ~pll_clk;
    always @(posedge pll_clk) ifc++;

    ups_seq i_dut (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .core_regulator_rail_in(rail),
        .chip_select_powerdown_pin_in(cs_pd), .hw_reset_n_in(rst_n), .stp_in(stp),
        .pll_clk_in(pll_clk), .pll_lock_in(lock), .func_reset_write_in(wr),
        .bus_protect_disable_bit_in(dis), .rxcmd_status_in(status), .pins_out(pins),
        .func_reset_bit_out(bit_o), .powered_down_out(pd), .internal_reset_out(ir));
    ups_link_model i_link (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in), .go_in(go),
        .dir_in(pins.dir), .ifclk_in(pins.clk), .hw_reset_n_in(rst_n), .stp_req_in(stp_req),
        .func_reset_write_out(wr), .stp_out(stp));

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    function automatic logic pick(input int s);
        case (s)
            0: return pins.dir;
            1: return ir;
            default: return bit_o;
        endcase
    endfunction

    // Waits are cut short by the cycle ceiling below
    task automatic wait_sig(input int s, input logic v);
        while (pick(s) !== v) begin
            @(posedge ref_clk_in);
            #1;
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask

    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            wrap_up();
        end
    end

    initial begin
        void'($urandom(32'h20F7BD58));
        repeat (12) @(posedge ref_clk_in);
        sys_rst_in <= 1'b0;
        step(2);
        check(8'(pd), 8'h01);
        check(8'({pins.clk_oe_n, pins.dir_oe_n, pins.nxt_oe_n, pins.data_oe_n}), 8'h0F);
        @(posedge ref_clk_in);
        cs_pd <= 1'b0;
        rail <= 1'b1;
        status <= 8'($urandom);
        // Link ignores the pins until go is raised, well after the POR has run out
        wait_sig(1, 1'b1);
        wait_sig(1, 1'b0);
        check(8'(pins.dir), 8'h01);
        check(8'(pins.nxt), 8'h00);
        check(pins.data, status);
        // PLL start-up takes a while after the pulse
        repeat (8) @(posedge ref_clk_in);
        lock <= 1'b1;
        wait_sig(0, 1'b0);
        check(8'(pins.clk_oe_n), 8'h00);
        check(8'(pins.data_oe_n), 8'h01);
        // 320 ns window holds exactly five 64 ns interface periods
        last_clk = pins.clk;
        rises = 0;
        repeat (64) begin
            step(1);
            if (pins.clk && !last_clk) begin
                rises++;
            end
            last_clk = pins.clk;
        end
        check(8'(rises), 8'h05);
        go <= 1'b1;
        wait_sig(2, 1'b1);
        check(8'(pins.dir), 8'h01);
        go <= 1'b0;
        wait_sig(2, 1'b0);
        check(8'(pins.dir), 8'h01);
        check(pins.data, status);
        wait_sig(0, 1'b0);
        check(8'(bit_o), 8'h00);
        for (int i = 0; i < 8; i++) begin
            @(posedge ref_clk_in);
            stp_req <= 1'($urandom);
            dis <= 1'($urandom);
            step(6);
            check(8'(pins.data_pulldown_en), 8'(stp & !dis));
        end
        check(8'(pins.stp_pullup_en), 8'h01);
        @(posedge ref_clk_in);
        rst_n <= 1'b0;
        stp_req <= 1'b0;
        step(6);
        check(8'({pins.dir, ir}), 8'h03);
        rst_n <= 1'b1;
        base = ifc;
        wait_sig(0, 1'b0);
        check(8'(ifc - base >= 4 && ifc - base <= 5), 8'h01);
        @(posedge ref_clk_in);
        rail <= 1'b0;
        step(20);
        rail <= 1'b1;
        step(30);
        check(8'(ir), 8'h00);
        rail <= 1'b0;
        step(60);
        rail <= 1'b1;
        step(40);
        check(8'(ir), 8'h01);
        cs_pd <= 1'b1;
        step(6);
        check(8'({pd, pins.dir_oe_n, pins.data_oe_n}), 8'h07);
        wrap_up();
    end
endmodule

bind ups_seq ups_seq_props i_props (.ref_clk_in(ref_clk_in), .sys_rst_in(sys_rst_in),
    .chip_select_powerdown_pin_in(chip_select_powerdown_pin_in), .hw_reset_n_in(hw_reset_n_in),
    .bus_protect_disable_bit_in(bus_protect_disable_bit_in), .pins_out(pins_out),
    .func_reset_bit_out(func_reset_bit_out), .powered_down_out(powered_down_out),
    .internal_reset_out(internal_reset_out));
`default_nettype wire
